// ===== cfc_pkg.sv
package cfc_pkg;
  // ==========================================================
  // Clock and register port
  // ==========================================================
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 16;
  localparam logic [6:0] CFG_ADDR = 7'h36;   // Converter configuration
  localparam logic [6:0] ENA_ADDR = 7'h37;   // Input channel enables
  localparam logic [6:0] SYNC_ADDR = 7'h3a;  // DAC update mode bits

  // ==========================================================
  // Configuration register fields
  // ==========================================================
  localparam int unsigned MODE_BIT = 13;
  localparam int unsigned TRIG_BIT = 12;
  localparam int unsigned LOAD_BIT = 11;
  localparam int unsigned RATE_LSB = 8;
  localparam int unsigned READY_BIT = 7;
  localparam logic [15:0] CFG_RESET = 16'h2000;
  localparam logic [15:0] CFG_RSVD_MASK = 16'hc47f;
  localparam logic [15:0] ENA_MASK = 16'h6de0;
  localparam logic [15:0] SYNC_MASK = 16'h000f;

  // ==========================================================
  // Channel counts and enable bit positions
  // ==========================================================
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned NUM_DAC = 4;
  localparam logic [3:0] ENA_POS [8] = '{4'he, 4'hd, 4'hb, 4'ha, 4'h8, 4'h7, 4'h6, 4'h5};
  localparam logic [3:0] LAST_IDX = 4'h8;

  // ==========================================================
  // Timing: one sample slot at the fastest rate (500 kSPS)
  // ==========================================================
  localparam int unsigned SAMPLE_NS = 2000;
  localparam logic [11:0] SAMPLE_CYC = 12'(SAMPLE_NS * CLK_MHZ / 1000);

  // Sequencer states
  typedef enum logic {SEQ_IDLE, SEQ_SCAN} cfc_seq_state_t;

  // Slot length in cycles for a rate code; each step halves the rate
  function automatic logic [11:0] cfc_period_cyc(input logic [1:0] rate);
    return SAMPLE_CYC << rate;
  endfunction

  // Gather the eight enable bits out of the enable register image
  function automatic logic [7:0] cfc_enables(input logic [15:0] img);
    logic [7:0] en;
    en = 8'h00;
    for (int i = 0; i < NUM_CH; i++)
    begin
      en[i] = img[ENA_POS[i]];
    end
    return en;
  endfunction
endpackage

// ===== cfc_seq_if.sv
interface cfc_seq_if;
  import cfc_pkg::*;
  logic start;          // Begin one conversion cycle
  logic [1:0] rate;     // Rate code for this cycle
  logic [7:0] enables;  // Inputs to visit
  logic busy;           // Cycle in progress
  logic done;           // Cycle finished, one pulse
  logic sampleStb;      // Take a sample now, one pulse
  logic [2:0] chanSel;  // Input being sampled
  modport seq (input start, rate, enables, output busy, done, sampleStb, chanSel);
  modport ctl (output start, rate, enables, input busy, done, sampleStb, chanSel);
endinterface

// ===== cfc_scan_seq.sv
module cfc_scan_seq
  import cfc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control side
  cfc_seq_if.seq sq
);
  // ==========================================================
  // State
  // ==========================================================
  cfc_seq_state_t state_r;    // Idle or scanning
  logic [3:0] idx_r;          // Next input to consider
  logic [11:0] waitCnt_r;     // Cycles left in current slot
  logic [7:0] enLat_r;        // Enables frozen for the cycle
  logic [1:0] rateLat_r;      // Rate frozen for the cycle
  logic done_r;
  logic sample_r;
  logic [2:0] chan_r;
  logic slotEnd;

  assign slotEnd = (waitCnt_r == 12'h000);
  assign sq.busy = (state_r != SEQ_IDLE);
  assign sq.done = done_r;
  assign sq.sampleStb = sample_r;
  assign sq.chanSel = chan_r;

  // Walk the inputs; disabled ones cost one cycle, enabled ones a slot
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= SEQ_IDLE;
      idx_r <= 4'h0;
      waitCnt_r <= 12'h000;
      enLat_r <= 8'h00;
      rateLat_r <= 2'h0;
      done_r <= 1'b0;
      sample_r <= 1'b0;
      chan_r <= 3'h0;
    end
    else
    begin
      done_r <= 1'b0;
      sample_r <= 1'b0;
      case (state_r)
        SEQ_IDLE:
        begin
          // Settings are frozen so a mid-cycle write cannot tear a scan
          if (sq.start)
          begin
            state_r <= SEQ_SCAN;
            idx_r <= 4'h0;
            waitCnt_r <= 12'h000;
            enLat_r <= sq.enables;
            rateLat_r <= sq.rate;
          end
        end
        SEQ_SCAN:
        begin
          if (!slotEnd)
          begin
            waitCnt_r <= waitCnt_r - 12'h001;
          end
          else if (idx_r == LAST_IDX)
          begin
            state_r <= SEQ_IDLE;
            done_r <= 1'b1;
          end
          else if (enLat_r[idx_r[2:0]])
          begin
            // Enabled input: sample and hold the slot
            sample_r <= 1'b1;
            chan_r <= idx_r[2:0];
            waitCnt_r <= cfc_period_cyc(rateLat_r) - 12'h001;
            idx_r <= idx_r + 4'h1;
          end
          else
          begin
            // Disabled input is skipped
            idx_r <= idx_r + 4'h1;
          end
        end
        default:
        begin
          state_r <= SEQ_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  logic [11:0] gapCnt_r;   // Cycles since the last sample in this scan
  logic gapValid_r;        // A sample was taken earlier in this scan
  always_ff @(posedge clk)
  begin
    if (rst || sq.start || sq.done)
    begin
      gapCnt_r <= 12'h000;
      gapValid_r <= 1'b0;
    end
    else if (sample_r)
    begin
      gapCnt_r <= 12'h001;
      gapValid_r <= 1'b1;
    end
    else if (gapCnt_r != 12'hfff)
    begin
      gapCnt_r <= gapCnt_r + 12'h001;
    end
  end

  property p_slot_len;
    @(posedge clk) disable iff (rst)
    sample_r && gapValid_r |-> gapCnt_r >= cfc_period_cyc(rateLat_r);
  endproperty
  a_slot_len: assert property (p_slot_len) else $error("sample slot too short");

  property p_only_enabled;
    @(posedge clk) disable iff (rst)
    sample_r |-> enLat_r[chan_r];
  endproperty
  a_only_enabled: assert property (p_only_enabled) else $error("disabled input sampled");
endmodule

// ===== cfc_converter_ctl.sv
// Notes on behaviour
// - Bit 13 picks automatic or direct conversion.
// - Bit 12 starts a cycle, clears itself.
// - Bit 11 loads synchronous DAC channels only.
// - Load updates only channels accessed since last.
// - Bits 9:8 set rate 500/250/125/62.5 kSPS.
// - Bit 7 reads one after direct cycle completes.
// - Completion flag zero while running or automatic.
// - Result read or new start clears completion.
// - Configuration register resets to 0x2000.
// - Per-channel bit picks synchronous or direct update.
// - Conversion samples only enabled analog inputs.
module cfc_converter_ctl
  import cfc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register access from the serial front end
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [6:0] regAddr,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  output logic regRdValid,
  // Host access events on other registers
  input wire logic [3:0] dacDataAccess,
  input wire logic adcResultRead,
  // Converter core controls
  output logic [3:0] dacUpdate,
  output logic adcSampleStb,
  output logic [2:0] adcChannel,
  output logic adcCycleDone
);
  // ==========================================================
  // Register state
  // ==========================================================
  logic mode_r;          // One for automatic conversion
  logic trig_r;          // Pending direct trigger
  logic [1:0] rate_r;    // Conversion rate code
  logic ready_r;         // Direct-mode completion flag
  logic [15:0] ena_r;    // Input channel enable image
  logic [3:0] sync_r;    // One for synchronous DAC update
  logic [3:0] pending_r; // DAC data accessed since last load
  logic [3:0] dacUpd_r;
  logic [15:0] rdata_r;
  logic rdValid_r;
  logic [15:0] cfgView;  // Configuration as software reads it
  logic cfgWr;
  logic loadStb;
  logic asyncHit;

  cfc_seq_if sq ();

  // ==========================================================
  // Sequencer
  // ==========================================================
  cfc_scan_seq u_seq (
    .clk(clk),
    .rst(rst),
    .sq(sq.seq)
  );

  // Automatic mode restarts whenever idle; direct mode waits for a trigger
  assign sq.start = !sq.busy && (mode_r || trig_r);
  assign sq.rate = rate_r;
  assign sq.enables = cfc_enables(ena_r);

  assign cfgWr = regWrite && (regAddr == CFG_ADDR);
  assign loadStb = cfgWr && regWdata[LOAD_BIT];
  assign asyncHit = |(dacDataAccess & ~sync_r);

  // Load bit and reserved bits never read back as one
  always_comb
  begin
    cfgView = 16'h0000;
    cfgView[MODE_BIT] = mode_r;
    cfgView[TRIG_BIT] = trig_r;
    cfgView[RATE_LSB +: 2] = rate_r;
    cfgView[READY_BIT] = ready_r;
  end

  // ==========================================================
  // Configuration register
  // ==========================================================
  // Mode and rate are plain storage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_r <= CFG_RESET[MODE_BIT];
      rate_r <= CFG_RESET[RATE_LSB +: 2];
    end
    else if (cfgWr)
    begin
      mode_r <= regWdata[MODE_BIT];
      rate_r <= regWdata[RATE_LSB +: 2];
    end
  end

  // Trigger clears once the sequencer takes it; a fresh write wins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      trig_r <= CFG_RESET[TRIG_BIT];
    end
    else if (cfgWr && regWdata[TRIG_BIT])
    begin
      trig_r <= 1'b1;
    end
    else if (sq.start)
    begin
      trig_r <= 1'b0;
    end
  end

  // Completion flag: completion set wins over a same-cycle result read,
  // but a start in the done cycle keeps it low because a new cycle runs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ready_r <= CFG_RESET[READY_BIT];
    end
    else if (mode_r || (cfgWr && regWdata[MODE_BIT]))
    begin
      // Cleared as auto mode is written, so it never reads one there
      ready_r <= 1'b0;
    end
    else if (sq.done && !sq.start)
    begin
      ready_r <= 1'b1;
    end
    else if (adcResultRead || sq.start)
    begin
      ready_r <= 1'b0;
    end
  end

  // ==========================================================
  // Neighbour registers steering this block
  // ==========================================================
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ena_r <= 16'h0000;
      sync_r <= 4'h0;
    end
    else if (regWrite)
    begin
      // Reserved bits are dropped so they always read zero
      if (regAddr == ENA_ADDR)
      begin
        ena_r <= regWdata & ENA_MASK;
      end
      if (regAddr == SYNC_ADDR)
      begin
        sync_r <= regWdata[3:0] & SYNC_MASK[3:0];
      end
    end
  end

  // ==========================================================
  // DAC update strobes
  // ==========================================================
  // Pending marks only synchronous channels; an access in the load cycle
  // stays pending for the next load so it is never lost
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pending_r <= 4'h0;
    end
    else
    begin
      pending_r <= ((pending_r & ~({4{loadStb}})) | dacDataAccess) & sync_r;
    end
  end

  // Direct channels follow each access; synchronous ones wait for load
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dacUpd_r <= 4'h0;
    end
    else
    begin
      dacUpd_r <= (dacDataAccess & ~sync_r)
                | (pending_r & sync_r & {4{loadStb}});
    end
  end

  // ==========================================================
  // Read port: data one cycle after the read request
  // ==========================================================
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_r <= 16'h0000;
      rdValid_r <= 1'b0;
    end
    else
    begin
      rdValid_r <= regRead;
      if (regRead)
      begin
        case (regAddr)
          CFG_ADDR: rdata_r <= cfgView;
          ENA_ADDR: rdata_r <= ena_r;
          SYNC_ADDR: rdata_r <= {12'h000, sync_r};
          default: rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  assign regRdata = rdata_r;
  assign regRdValid = rdValid_r;
  assign dacUpdate = dacUpd_r;
  assign adcSampleStb = sq.sampleStb;
  assign adcChannel = sq.chanSel;
  assign adcCycleDone = sq.done;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_reset_val;
    @(posedge clk) $fell(rst) |-> cfgView == CFG_RESET;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("bad reset image");

  property p_auto_runs;
    mode_r && !sq.busy && !rst |=> sq.busy;
  endproperty
  a_auto_runs: assert property (p_auto_runs) else $error("auto mode idle");

  property p_trig_clear;
    trig_r && !sq.busy && !cfgWr |=> !trig_r && sq.busy;
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger not taken");

  property p_ready_set;
    !mode_r && sq.done && !sq.start ##1 !mode_r |-> ready_r;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready not set");

  property p_ready_zero;
    sq.busy || mode_r |-> !ready_r;
  endproperty
  a_ready_zero: assert property (p_ready_zero) else $error("ready while busy/auto");

  property p_ready_clear;
    ready_r && adcResultRead && !sq.done |=> !ready_r;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");

  property p_load_pending;
    (dacUpd_r & $past(sync_r)) != 4'h0 |-> $past(loadStb);
  endproperty
  a_load_pending: assert property (p_load_pending) else $error("sync update without load");

  property p_async_follow;
    asyncHit |=> (dacUpd_r & ~$past(sync_r)) == ($past(dacDataAccess) & ~$past(sync_r));
  endproperty
  a_async_follow: assert property (p_async_follow) else $error("async channel missed");

  property p_rsvd_zero;
    regRead && regAddr == CFG_ADDR |=> (regRdata & CFG_RSVD_MASK) == 16'h0000 && !regRdata[LOAD_BIT];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read one");

  c_direct_done: cover property (!mode_r && sq.done ##1 ready_r);
  c_sync_load: cover property (loadStb && (pending_r != 4'h0));
  c_auto_scan: cover property (mode_r && sq.sampleStb);
endmodule

// ===== cfc_host_model.sv
// ==========================================================
// Host model: register traffic and access events toward the device
// ==========================================================
module cfc_host_model
  import cfc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output logic regWrite,
  output logic regRead,
  output logic [6:0] regAddr,
  output logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic regRdValid,
  // Access events on other registers
  output logic [3:0] dacDataAccess,
  output logic adcResultRead
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quiet bus from time zero
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 7'h00;
    regWdata = 16'h0000;
    dacDataAccess = 4'h0;
    adcResultRead = 1'b0;
  end

  // One access: raised after an edge, held over the taking edge
  task automatic issue(input logic wr, input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    regWrite = wr;
    regRead = ~wr;
    regAddr = a;
    regWdata = d;
    @(posedge clk);
    #1;
    regWrite = 1'b0;
    regRead = 1'b0;
    // Idle lines flip, so a stale word never passes for a live one
    regAddr = ~a;
    regWdata = ~d;
  endtask

  // Read one word; unknown comes back if no answer shows
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    d = 16'hxxxx;
    issue(1'b0, a, 16'h0000);
    for (int k = 0; k < 4; k++)
    begin
      if (regRdValid === 1'b1)
      begin
        d = regRdata;
        break;
      end
      @(posedge clk);
      #1;
    end
  endtask

  // One-cycle access events
  task automatic pulse(input logic [3:0] acc, input logic res);
    @(posedge clk);
    #1;
    dacDataAccess = acc;
    adcResultRead = res;
    @(posedge clk);
    #1;
    dacDataAccess = 4'h0;
    adcResultRead = 1'b0;
  endtask
endmodule

// ===== converter_config_control_tb.sv
// ==========================================================
// Testbench for the converter control block
// ==========================================================
module converter_config_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cfc_pkg::*;

  logic clk = 1'b0;  // 125 MHz
  logic rst = 1'b1;  // Synchronous, active high
  logic regWrite, regRead, regRdValid, adcResultRead, adcSampleStb, adcCycleDone;
  logic [6:0] regAddr;
  logic [15:0] regWdata, regRdata;
  logic [3:0] dacDataAccess, dacUpdate;
  logic [2:0] adcChannel;
  int failCount = 0;
  int totalChecks = 0;
  int cyc = 0;  // Edge counter for scan timing
  int firstCyc, doneCyc;
  int doneCount = 0;
  logic [2:0] chans[$];  // Inputs sampled in this scan

  always #4 clk = ~clk;

  cfc_converter_ctl DUT (.clk(clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
    .dacDataAccess(dacDataAccess), .adcResultRead(adcResultRead), .dacUpdate(dacUpdate),
    .adcSampleStb(adcSampleStb), .adcChannel(adcChannel), .adcCycleDone(adcCycleDone));

  cfc_host_model host (.clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
    .dacDataAccess(dacDataAccess), .adcResultRead(adcResultRead));

  // Scan monitor; every edge sees the previous cycle, so spacings hold
  always @(posedge clk)
  begin
    cyc++;
    if (adcSampleStb === 1'b1)
    begin
      if (chans.size() == 0)
        firstCyc = cyc;
      chans.push_back(adcChannel);
    end
    if (adcCycleDone === 1'b1)
    begin
      doneCount++;
      doneCyc = cyc;
    end
  end

  // ==========================================================
  // Expectations and comparisons
  // ==========================================================
  // Scan length: a full slot per enabled input, one cycle per skip
  function automatic int scanCost(input logic [7:0] en, input logic [1:0] r);
    int c;
    c = 0;
    for (int i = 0; i < 8; i++)
      c += en[i] ? (250 << r) : 1;
    return c;
  endfunction

  // Enable register image; the input bits are scattered
  function automatic logic [15:0] enaImg(input logic [7:0] en);
    logic [15:0] img;
    img = 16'h0000;
    for (int i = 0; i < 8; i++)
      img[ENA_POS[i]] = en[i];
    return img;
  endfunction

  task automatic chkReg(input string what, input logic [15:0] e, input logic [15:0] g);
    totalChecks++;
    if (g !== e)
    begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chkVal(input string what, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e)
    begin
      failCount++;
      $display("MISMATCH %s expected %0d seen %0d", what, e, g);
    end
  endtask

  // Verdict and end of run
  task automatic wrapUp();
    if (failCount == 0 && totalChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog well beyond the longest expected run
  initial
  begin
    #(90000 * 8);
    failCount++;
    wrapUp();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    logic [15:0] d;
    logic [15:0] e;
    logic [7:0] en;
    logic [3:0] sync, acc;
    int j, n;
    n = $urandom(71);
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    host.rd(CFG_ADDR, d);
    chkReg("cfgReset", CFG_RESET, d);
    host.rd(7'h3b, d);
    chkReg("unmapped", 16'h0000, d);
    // Reserved and ready bits written as ones must read back zero
    host.issue(1'b1, CFG_ADDR, 16'he4ff);
    host.rd(CFG_ADDR, d);
    chkReg("cfgRsvd", 16'h2000, d);
    // Automatic mode reruns scans with no trigger
    host.issue(1'b1, ENA_ADDR, enaImg(8'h01));
    doneCount = 0;
    repeat (600) @(posedge clk);
    chkVal("autoRuns", 1, doneCount >= 2);
    // Direct mode; the running auto scan (257 cycles) drains first
    host.issue(1'b1, CFG_ADDR, 16'h0000);
    repeat (600) @(posedge clk);
    for (int r = 0; r < 4; r++)
    begin
      en = 8'($urandom) | 8'h01;
      host.issue(1'b1, ENA_ADDR, enaImg(en));
      chans.delete();
      doneCount = 0;
      e = {6'h00, 2'(r), 8'h00};
      host.issue(1'b1, CFG_ADDR, e | 16'h1000);
      host.rd(CFG_ADDR, d);
      chkReg("cfgRunning", e, d);
      for (int k = 0; k < 20000 && doneCount == 0; k++)
        @(posedge clk);
      #1;
      chkVal("scanLen", scanCost(en, 2'(r)), doneCyc - firstCyc);
      chkVal("scanCount", $countones(en), chans.size());
      j = 0;
      for (int i = 0; i < 8; i++)
        if (en[i])
        begin
          chkVal("chan", i, (j < chans.size()) ? 32'(chans[j]) : 'x);
          j++;
        end
      host.rd(CFG_ADDR, d);
      chkReg("cfgReady", e | 16'h0080, d);
      repeat (300) @(posedge clk);
      chkVal("noRerun", 1, doneCount);
      // Even rates clear the flag by result read, rate 1 by the next trigger, rate 3 by the result read after the loop
      if (r % 2 == 0)
      begin
        host.pulse(4'h0, 1'b1);
        host.rd(CFG_ADDR, d);
        chkReg("cfgReadClr", e, d);
      end
    end
    host.pulse(4'h0, 1'b1);
    // DAC strobes: asynchronous at once, synchronous only on load
    for (int t = 0; t < 6; t++)
    begin
      sync = 4'($urandom);
      acc = (t == 0) ? 4'hf : 4'($urandom);
      host.issue(1'b1, SYNC_ADDR, {12'h000, sync});
      // Update pulses stand one cycle, right after the taking edge
      host.pulse(acc, 1'b0);
      chkVal("dacAsync", acc & ~sync, dacUpdate);
      host.issue(1'b1, CFG_ADDR, 16'h0800);
      chkVal("dacLoad", acc & sync, dacUpdate);
      host.issue(1'b1, CFG_ADDR, 16'h0800);
      chkVal("dacReload", 0, dacUpdate);
      host.rd(CFG_ADDR, d);
      chkReg("cfgLoadBit", 16'h0000, d);
    end
    // Mid-run reset brings the configuration back from direct mode
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chkVal("dacRst", 0, dacUpdate);
    host.rd(CFG_ADDR, d);
    chkReg("cfgReReset", CFG_RESET, d);
    wrapUp();
  end
endmodule
